// File: design/pst_pkg.sv
// Package for the power-up self-test sequencer: test numbers, states, codes.
// Assumes one 40 MHz clock domain; shared by the sequencer and the testbench.
package pst_pkg;

  // ****************************************
  // Test numbering
  // ****************************************
  localparam logic [2:0] TEST_PROG_MEM   = 3'h0;
  localparam logic [2:0] TEST_WORK_MEM   = 3'h1;
  localparam logic [2:0] TEST_DISPLAY    = 3'h2;
  localparam logic [2:0] TEST_RUN_DATA   = 3'h3;
  localparam logic [2:0] TEST_USER_PROG  = 3'h4;
  localparam logic [2:0] TEST_STORE_ALL  = 3'h5;
  localparam logic [2:0] TEST_LAST       = 3'h5;
  localparam int         TEST_COUNT      = 6;

  // ****************************************
  // Serial reply characters (ASCII)
  // ****************************************
  localparam logic [7:0] CHAR_NEG        = 8'h4E;
  localparam logic [7:0] CHAR_DIGIT0     = 8'h30;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         CLK_MHZ         = 40;
  localparam int         TEST_TMO_US     = 100;
  localparam int         TEST_TMO_CYC    = TEST_TMO_US * CLK_MHZ;
  localparam logic [12:0] TMO_RESET      = 13'h0000;

  // ****************************************
  // Sequencer states, Gray coded along the pass path IDLE, START, WAIT, RUN
  // ****************************************
  typedef enum logic [2:0] {
    PST_IDLE    = 3'b000,
    PST_START   = 3'b001,
    PST_WAIT    = 3'b011,
    PST_RUN     = 3'b010,
    PST_ERROR   = 3'b110,
    PST_RECOVER = 3'b111
  } pst_state_e;

endpackage : pst_pkg

// File: design/pst_sequencer.sv
// Power-up self-test sequencer and error-mode handler for a preset counter.
// Assumes the six test engines, the store repair engine and the serial link
// sit on mclk; the front-panel key is an unsynchronised pin.
// Summary of operation
// - Run all self-tests after every power-up before normal counting begins.
// - On failure show an error message carrying the failed test digit.
// - While an error is shown, suspend counting and control operation.
// - In error, hold relay and both transistor outputs off.
// - In error, answer each serial command with N and the test number.
// - Test zero checks the program memory is not corrupted.
// - Test one checks the working read/write memory.
// - Test two checks the display driver circuitry.
// - Test three checks the run-data section of the nonvolatile store.
// - Test four checks the user-program section of the nonvolatile store.
// - Test five checks overall integrity of the nonvolatile store.
// - Run-data section keeps counts and presets across power loss.
// - User-program section keeps options and parameters across power loss.
// - Error three plus reset key zeroes counts and presets, then retests.
// - Error four plus reset key loads factory options, then retests.
`timescale 1ns/1ps
module pst_sequencer
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Test engines, one bit per test number
  output logic [5:0]      test_start,
  input  wire logic [5:0] test_done,
  input  wire logic [5:0] test_pass,
  // Front-panel reset key pin
  input  wire logic       reset_key,
  // Nonvolatile store repair
  output logic            clear_run_data,
  output logic            load_factory,
  input  wire logic       repair_done,
  // Serial command handling
  input  wire logic       cmd_valid,
  output logic            cmd_exec,
  output logic            reply_valid,
  output logic [7:0]      reply_char0,
  output logic [7:0]      reply_char1,
  // Run state, outputs and display
  output logic            run_enable,
  output logic            outputs_allowed,
  output logic            err_show,
  output logic [2:0]      err_digit
);

  // ****************************************
  // Registers
  // ****************************************
  pst_pkg::pst_state_e state;
  pst_pkg::pst_state_e next_state;
  logic [2:0]          test_idx;
  logic [2:0]          next_test_idx;
  logic [12:0]         tmo;
  logic                key_s1;
  logic                key_s2;
  logic                key_d;

  // ****************************************
  // Decode
  // ****************************************
  // One-hot select of the current test number.
  function automatic logic [5:0] sel_test(input logic [2:0] idx);
    sel_test = 6'h01 << idx;
  endfunction

  wire        key_press  = key_s2 & ~key_d;
  wire        cur_done   = |(test_done & sel_test(test_idx));
  wire        cur_pass   = |(test_pass & sel_test(test_idx));
  // A hung engine counts as a failure so a test can never stall the sequencer.
  wire        tmo_hit    = (tmo == 13'(pst_pkg::TEST_TMO_CYC - 1));
  wire        fail_now   = (cur_done & ~cur_pass) | tmo_hit;
  // Only the two store-section errors can be repaired from the panel.
  wire        fixable    = (test_idx == pst_pkg::TEST_RUN_DATA) |
                           (test_idx == pst_pkg::TEST_USER_PROG);
  wire        in_error   = (state == pst_pkg::PST_ERROR);

  // Next state; strictly ascending, stop at first failing test.
  always_comb
  begin
    next_state    = state;
    next_test_idx = test_idx;
    unique case (state)
      pst_pkg::PST_IDLE:
      begin
        next_state    = pst_pkg::PST_START;
        next_test_idx = pst_pkg::TEST_PROG_MEM;
      end
      pst_pkg::PST_START:
        next_state = pst_pkg::PST_WAIT;
      pst_pkg::PST_WAIT:
      begin
        if (fail_now)
          next_state = pst_pkg::PST_ERROR;
        else if (cur_done && test_idx == pst_pkg::TEST_LAST)
          next_state = pst_pkg::PST_RUN;
        else if (cur_done)
        begin
          next_state    = pst_pkg::PST_START;
          next_test_idx = test_idx + 3'h1;
        end
      end
      pst_pkg::PST_RUN:
        next_state = pst_pkg::PST_RUN;
      pst_pkg::PST_ERROR:
        if (key_press && fixable)
          next_state = pst_pkg::PST_RECOVER;
      pst_pkg::PST_RECOVER:
        if (repair_done)
          next_state = pst_pkg::PST_IDLE;
      default:
        next_state = pst_pkg::PST_IDLE;
    endcase
  end

  // ****************************************
  // State, key synchroniser and watchdog
  // ****************************************
  // The key pin passes two flops before the edge detector looks at it.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state    <= pst_pkg::PST_IDLE;
      test_idx <= pst_pkg::TEST_PROG_MEM;
      key_s1   <= 1'b0;
      key_s2   <= 1'b0;
      key_d    <= 1'b0;
      tmo      <= pst_pkg::TMO_RESET;
    end
    else
    begin
      state    <= next_state;
      test_idx <= next_test_idx;
      key_s1   <= reset_key;
      key_s2   <= key_s1;
      key_d    <= key_s2;
      tmo      <= (state == pst_pkg::PST_WAIT) ? tmo + 13'h0001 : pst_pkg::TMO_RESET;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Every output is a flop; outputs and counting open only after all tests pass.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      test_start      <= 6'h00;
      clear_run_data  <= 1'b0;
      load_factory    <= 1'b0;
      cmd_exec        <= 1'b0;
      reply_valid     <= 1'b0;
      reply_char0     <= 8'h00;
      reply_char1     <= 8'h00;
      run_enable      <= 1'b0;
      outputs_allowed <= 1'b0;
      err_show        <= 1'b0;
      err_digit       <= 3'h0;
    end
    else
    begin
      // Test numbers map to engines 0..5: program memory, work memory, display,
      // run-data, user-program and whole-store checks.
      test_start      <= (next_state == pst_pkg::PST_START) ?
                         sel_test(next_test_idx) : 6'h00;
      // Repair strobes; the store engine keeps data across power loss itself.
      clear_run_data  <= in_error & key_press &
                         (test_idx == pst_pkg::TEST_RUN_DATA);
      load_factory    <= in_error & key_press &
                         (test_idx == pst_pkg::TEST_USER_PROG);
      cmd_exec        <= cmd_valid & (state == pst_pkg::PST_RUN);
      reply_valid     <= cmd_valid & in_error;
      reply_char0     <= pst_pkg::CHAR_NEG;
      reply_char1     <= pst_pkg::CHAR_DIGIT0 + {5'h00, test_idx};
      run_enable      <= (next_state == pst_pkg::PST_RUN);
      outputs_allowed <= (next_state == pst_pkg::PST_RUN);
      err_show        <= (next_state == pst_pkg::PST_ERROR);
      err_digit       <= next_test_idx;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_fail_seen;
    (state == pst_pkg::PST_WAIT) && fail_now;
  endsequence

  chk_fail_shows_error: assert property (@(posedge mclk) disable iff (rst)
    s_fail_seen |=> err_show && (err_digit == $past(test_idx)))
    else $error("Failed test not shown with its digit.");

  chk_error_stops_run: assert property (@(posedge mclk) disable iff (rst)
    err_show |-> !run_enable)
    else $error("Counting runs while an error is shown.");

  chk_error_outputs_off: assert property (@(posedge mclk) disable iff (rst)
    err_show |-> !outputs_allowed)
    else $error("Outputs allowed during error.");

  chk_neg_reply: assert property (@(posedge mclk) disable iff (rst)
    (cmd_valid && in_error) |=> reply_valid && !cmd_exec &&
    reply_char0 == 8'h4E && reply_char1 == (8'h30 + {5'h00, $past(test_idx)}))
    else $error("Error reply wrong or command executed.");

  chk_run_after_tests: assert property (@(posedge mclk) disable iff (rst)
    $rose(run_enable) |-> $past(test_idx) == pst_pkg::TEST_LAST)
    else $error("Run began before the last test.");

  chk_order_up: assert property (@(posedge mclk) disable iff (rst)
    (state == pst_pkg::PST_WAIT && cur_done && !fail_now &&
     test_idx != pst_pkg::TEST_LAST) |=> test_idx == $past(test_idx) + 3'h1 &&
    test_start == sel_test(test_idx))
    else $error("Tests not run in ascending order.");

  // The display drops at the same edge that launches the strobe, so look one cycle back.
  chk_clear_runs: assert property (@(posedge mclk) disable iff (rst)
    clear_run_data |-> $past(err_show) && err_digit == pst_pkg::TEST_RUN_DATA)
    else $error("Run data cleared outside error three.");

  chk_factory_load: assert property (@(posedge mclk) disable iff (rst)
    load_factory |-> $past(err_show) && err_digit == pst_pkg::TEST_USER_PROG)
    else $error("Factory load outside error four.");

  chk_retest: assert property (@(posedge mclk) disable iff (rst)
    (state == pst_pkg::PST_RECOVER && repair_done) |-> ##2
    test_start == 6'h01)
    else $error("Tests not re-run after repair.");

endmodule // pst_sequencer

// File: testbench/pst_engine_model.sv
// Behavioural test engines and store repair engine facing the sequencer.
// Assumes mclk is shared; the bench picks failing tests and answer delay.
`timescale 1ns/1ps
module pst_engine_model
(
  // Clock
  input  wire logic       mclk,
  // Bench control
  input  wire logic [5:0] fail_mask,
  input  wire logic [3:0] lat,
  input  wire logic       mute,
  // Sequencer side
  input  wire logic [5:0] test_start,
  output logic [5:0]      test_done = 6'h00,
  output logic [5:0]      test_pass = 6'h00,
  input  wire logic       clear_run_data,
  input  wire logic       load_factory,
  output logic            repair_done = 1'b0
);
  logic [4:0] cnt = 5'h00;
  logic [2:0] cur = 3'h0;

  // One engine answers lat+1 cycles after its start; pass is garbage while
  // done is low, so a sequencer that samples it early is caught.
  always @(posedge mclk)
  begin
    test_done   <= 6'h00;
    test_pass   <= ~test_pass;
    repair_done <= clear_run_data | load_factory;
    if (test_start != 6'h00)
    begin
      cnt <= {1'b0, lat} + 5'h01;
      for (int i = 0; i < 6; i++)
        if (test_start[i])
          cur <= 3'(i);
    end
    else if (cnt == 5'h01)
    begin
      test_done[cur] <= ~mute;
      test_pass[cur] <= ~fail_mask[cur];
      cnt            <= 5'h00;
    end
    else if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
  end
endmodule // pst_engine_model

// File: testbench/testbench.sv
// Self-checking bench for the power-up self-test sequencer.
// Assumes the engine model answers every start unless muted; keys and commands from here.
`timescale 1ns/1ps
module testbench;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       reset_key = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       mute = 1'b0;
  logic [5:0] fail_mask = 6'h00;
  logic [3:0] lat = 4'h1;
  logic [5:0] test_start, test_done, test_pass;
  logic       clear_run_data, load_factory, repair_done, cmd_exec, reply_valid;
  logic [7:0] reply_char0, reply_char1;
  logic       run_enable, outputs_allowed, err_show;
  logic [2:0] err_digit, exp_next = 3'h0;
  int         error_cnt = 0, tests_run = 0, cycles = 0, starts = 0, clears = 0, loads = 0;
  int         seed = 32'hcc8b;

  always #12.5 mclk = ~mclk;

  pst_sequencer pst_sequencer_inst (.mclk(mclk), .rst(rst), .test_start(test_start),
    .test_done(test_done), .test_pass(test_pass), .reset_key(reset_key),
    .clear_run_data(clear_run_data), .load_factory(load_factory),
    .repair_done(repair_done), .cmd_valid(cmd_valid), .cmd_exec(cmd_exec),
    .reply_valid(reply_valid), .reply_char0(reply_char0), .reply_char1(reply_char1),
    .run_enable(run_enable), .outputs_allowed(outputs_allowed), .err_show(err_show),
    .err_digit(err_digit));
  pst_engine_model pst_engine_model_inst (.mclk(mclk), .fail_mask(fail_mask), .lat(lat),
    .mute(mute),
    .test_start(test_start), .test_done(test_done), .test_pass(test_pass),
    .clear_run_data(clear_run_data), .load_factory(load_factory),
    .repair_done(repair_done));

  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok)
    begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Start order watch; a repair pulse means the whole sequence restarts.
  always @(posedge mclk)
  begin
    cycles++;
    if (test_start !== 6'h00)
    begin
      chk(test_start === (6'h01 << exp_next), "start order");
      exp_next <= exp_next + 3'h1;
      starts++;
    end
    clears += (clear_run_data === 1'b1);
    loads  += (load_factory === 1'b1);
    if (clear_run_data === 1'b1 || load_factory === 1'b1)
      exp_next <= 3'h0;
    // The ceiling check comes last so that nothing runs after the verdict.
    if (cycles > 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic power_up(input logic [5:0] mask);
    fail_mask <= mask;
    lat       <= 4'($random(seed));
    rst       <= 1'b1;
    repeat (2) @(posedge mclk);
    rst      <= 1'b0;
    exp_next = 3'h0;
    starts   = 0;
    clears   = 0;
    loads    = 0;
  endtask

  // Bounded wait for the sequence to land in run or in error.
  task automatic settle();
    int n;
    n = 0;
    while (run_enable !== 1'b1 && err_show !== 1'b1 && n < 600)
    begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
  endtask

  // Two back-to-back commands; counts execute and reply pulses.
  // Outputs are read at each edge before it updates them, so every pulse is seen.
  task automatic cmd(output int ex, output int rp);
    ex = 0;
    rp = 0;
    cmd_valid <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge mclk);
      if (i == 1)
        cmd_valid <= 1'b0;
      ex += (cmd_exec === 1'b1);
      rp += (reply_valid === 1'b1);
    end
  endtask

  initial
  begin
    int ex, rp, k;
    logic [5:0] m;
    power_up(6'h00);
    settle();
    chk(run_enable === 1'b1 && outputs_allowed === 1'b1 && err_show === 1'b0, "no run");
    chk(starts == 6, "test count");
    cmd(ex, rp);
    chk(ex == 2 && rp == 0, "run command");
    // A silent engine must be turned into error zero by the watchdog.
    mute <= 1'b1;
    power_up(6'h00);
    k = 0;
    while (err_show !== 1'b1 && k < 5000)
    begin
      @(posedge mclk);
      k++;
    end
    chk(k >= pst_pkg::TEST_TMO_CYC && k <= pst_pkg::TEST_TMO_CYC + 4, "timeout span");
    chk(err_digit === pst_pkg::TEST_PROG_MEM && run_enable === 1'b0, "timeout digit");
    mute <= 1'b0;
    for (int n = 0; n < 6; n++)
    begin
      m = 6'h01 << n;
      power_up((6'($random(seed)) | m) & ~(m - 6'h01));
      settle();
      chk(err_show === 1'b1 && err_digit === 3'(n), "digit");
      chk(run_enable === 1'b0, "run in error");
      chk(outputs_allowed === 1'b0, "outputs in error");
      chk(starts == n + 1, "tests after failure");
      cmd(ex, rp);
      chk(ex == 0 && rp == 2, "reply count");
      chk(reply_char0 === pst_pkg::CHAR_NEG && reply_char1 === 8'h30 + 8'(n), "reply");
      fail_mask <= 6'h00;
      reset_key <= 1'b1;
      repeat (4) @(posedge mclk);
      reset_key <= 1'b0;
      repeat (8) @(posedge mclk);
      settle();
      chk(clears == (n == 3) && loads == (n == 4), "repair pulse");
      chk(run_enable === (n == 3 || n == 4), "recovery outcome");
    end
    stop_test();
  end
endmodule // testbench
